//--- logic/sum_pkg.sv
// package with offsets, fields, reset values and types of the supply undervoltage monitor
// How it works
// - monitor is active out of reset, comparing against the falling threshold
// - power-disable bit turns the monitor off: no status updates, no resets
// - reset-disable bit blocks system reset; the status flag still updates
// - in stop mode it runs only with power-disable clear and stop-enable set
// - trip-range select resets to zero (low range); one selects the high range
// - trip-range select is write-once after reset
// - flag sets below falling threshold, clears above rising, else holds
// - while active with resets enabled, a triggered reset holds until supply rises above the rising threshold
// - with both disable bits clear, a supply drop resets the chip
// - comparator drives the flag so software can poll with resets disabled
// - the monitor raises irq from its sticky event status bits masked by the enable register
// - when enabled it keeps running in wait mode and may reset out of wait
// - selecting high range while below its rising threshold resets at once
package sum_pkg;
    localparam logic [3:0] SUM_OFS_STATUS = 4'h0;
    localparam logic [3:0] SUM_OFS_CONFIG = 4'h1;
    localparam logic [3:0] SUM_OFS_IRQ_STATUS = 4'h2;
    localparam logic [3:0] SUM_OFS_IRQ_ENABLE = 4'h3;
    localparam logic [3:0] SUM_OFS_IRQ_CLEAR = 4'h4;
    localparam int SUM_BIT_FLAG = 7;
    localparam int SUM_BIT_STOP = 0;
    localparam int SUM_BIT_PWRD = 1;
    localparam int SUM_BIT_RSTD = 2;
    localparam int SUM_BIT_TRIP = 3;
    localparam int SUM_BIT_LOCK = 4;
    localparam int SUM_EV_LOW = 0;
    localparam int SUM_EV_RECOVER = 1;
    localparam int SUM_EV_RESET = 2;
    localparam logic [7:0] SUM_CONFIG_RST = 8'h00;
    localparam logic [2:0] SUM_IRQ_RST = 3'h0;

    typedef enum logic [1:0] {
        SUM_RUN = 2'b00,
        SUM_HOLD = 2'b01,
        SUM_OFF = 2'b10
    } sum_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sum_bus_req_t;

    typedef struct packed {
        logic stop_mode;
        logic wait_mode;
    } sum_power_mode_t;

    typedef struct packed {
        logic below_fall;
        logic above_rise;
    } sum_cmp_t;
endpackage : sum_pkg

//--- logic/sum_monitor.sv
// control logic of the supply undervoltage monitor with a register port
`timescale 1ns/1ps
module sum_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire sum_pkg::sum_bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire sum_pkg::sum_power_mode_t power_mode,
    input wire sum_pkg::sum_cmp_t cmp_lo,
    input wire sum_pkg::sum_cmp_t cmp_hi,
    output logic range_high,
    output logic monitor_on,
    output logic low_supply_reset,
    output logic irq
);
    import sum_pkg::*;

    typedef struct packed {
        sum_cmp_t lo_meta;
        sum_cmp_t lo_sync;
        sum_cmp_t hi_meta;
        sum_cmp_t hi_sync;
        logic flag;
        logic stop_en;
        logic pwrd;
        logic rstd;
        logic trip;
        logic locked;
        sum_state_t state;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic [7:0] rdata;
    } sum_regs_t;

    sum_regs_t q;
    sum_regs_t d;
    logic rst_int_n;
    sum_cmp_t cmp;
    logic active;
    logic [2:0] events;
    logic cfg_wr;
    logic clr_wr;
    logic en_wr;
    // kept apart from the state struct: it runs on the raw reset, not on its own copy
    logic [1:0] rst_sync_q;

    // one-cycle write strobe aimed at the given register
    function automatic logic reg_hit(input sum_bus_req_t req, input logic [3:0] ofs);
        reg_hit = req.wr && (req.addr == ofs);
    endfunction : reg_hit

    // copy of reset released through two flip-flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_q[1];

    // comparator for the chosen range; only second sync stage is read
    assign cmp = q.trip ? q.hi_sync : q.lo_sync;
    // off when power-disabled, or in stop without stop-enable
    assign active = !q.pwrd && !(power_mode.stop_mode && !q.stop_en);
    // register write decodes
    assign cfg_wr = reg_hit(bus_req, SUM_OFS_CONFIG);
    assign clr_wr = reg_hit(bus_req, SUM_OFS_IRQ_CLEAR);
    assign en_wr = reg_hit(bus_req, SUM_OFS_IRQ_ENABLE);

    always_comb begin
        d = q;
        events = 3'h0;
        d.lo_meta = cmp_lo;
        d.lo_sync = q.lo_meta;
        d.hi_meta = cmp_hi;
        d.hi_sync = q.hi_meta;
        // configuration; trip-range bit accepted only on first write
        if (cfg_wr) begin
            d.stop_en = bus_req.wdata[SUM_BIT_STOP];
            d.pwrd = bus_req.wdata[SUM_BIT_PWRD];
            d.rstd = bus_req.wdata[SUM_BIT_RSTD];
            if (!q.locked) begin
                d.trip = bus_req.wdata[SUM_BIT_TRIP];
                d.locked = 1'b1;
            end
        end
        // hysteretic flag: below falling sets, above rising clears, else holds
        if (active) begin
            if (cmp.below_fall && !q.flag) begin
                d.flag = 1'b1;
                events[SUM_EV_LOW] = 1'b1;
            end else if (cmp.above_rise && q.flag) begin
                d.flag = 1'b0;
                events[SUM_EV_RECOVER] = 1'b1;
            end
        end
        // reset state machine
        case (q.state)
            SUM_RUN: begin
                if (!active) begin
                    d.state = SUM_OFF;
                end else if (!q.rstd && (cmp.below_fall || (q.trip && !cmp.above_rise))) begin
                    d.state = SUM_HOLD;
                    events[SUM_EV_RESET] = 1'b1;
                end
            end
            SUM_HOLD: begin
                // while active with resets enabled, leaving needs the rising threshold, not just the falling one
                if (!active || q.rstd) begin
                    d.state = active ? SUM_RUN : SUM_OFF;
                end else if (cmp.above_rise) begin
                    d.state = SUM_RUN;
                end
            end
            SUM_OFF: begin
                if (active) begin
                    d.state = SUM_RUN;
                end
            end
            default: begin
                d.state = SUM_RUN;
            end
        endcase
        // sticky status: hardware set wins over software clear
        if (clr_wr) begin
            d.irq_status = q.irq_status & ~bus_req.wdata[2:0];
        end
        d.irq_status = d.irq_status | events;
        if (en_wr) begin
            d.irq_enable = bus_req.wdata[2:0];
        end
        // read data, valid the cycle after the strobe
        d.rdata = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                SUM_OFS_STATUS: d.rdata[SUM_BIT_FLAG] = q.flag;
                SUM_OFS_CONFIG: d.rdata = {3'h0, q.locked, q.trip, q.rstd, q.pwrd, q.stop_en};
                SUM_OFS_IRQ_STATUS: d.rdata = {5'h00, q.irq_status};
                SUM_OFS_IRQ_ENABLE: d.rdata = {5'h00, q.irq_enable};
                default: d.rdata = 8'h00;
            endcase
        end
    end

    // state register, cleared to defaults: monitor on, low range, unlocked
    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            q.lo_meta <= '0;
            q.lo_sync <= '0;
            q.hi_meta <= '0;
            q.hi_sync <= '0;
            q.flag <= 1'b0;
            q.stop_en <= SUM_CONFIG_RST[SUM_BIT_STOP];
            q.pwrd <= SUM_CONFIG_RST[SUM_BIT_PWRD];
            q.rstd <= SUM_CONFIG_RST[SUM_BIT_RSTD];
            q.trip <= SUM_CONFIG_RST[SUM_BIT_TRIP];
            q.locked <= 1'b0;
            q.state <= SUM_RUN;
            q.irq_status <= SUM_IRQ_RST;
            q.irq_enable <= SUM_IRQ_RST;
            q.rdata <= 8'h00;
        end else begin
            q.lo_meta <= d.lo_meta;
            q.lo_sync <= d.lo_sync;
            q.hi_meta <= d.hi_meta;
            q.hi_sync <= d.hi_sync;
            q.flag <= d.flag;
            q.stop_en <= d.stop_en;
            q.pwrd <= d.pwrd;
            q.rstd <= d.rstd;
            q.trip <= d.trip;
            q.locked <= d.locked;
            q.state <= d.state;
            q.irq_status <= d.irq_status;
            q.irq_enable <= d.irq_enable;
            q.rdata <= d.rdata;
        end
    end

    // outputs; irq is the OR of the sticky event status bits masked by their enables
    assign rd_data = q.rdata;
    assign range_high = q.trip;
    assign monitor_on = active;
    assign low_supply_reset = (q.state == SUM_HOLD);
    assign irq = |(q.irq_status & q.irq_enable);

    hold_until_rise_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (low_supply_reset && active && !q.rstd && !cmp.above_rise) |=> low_supply_reset)
        else $error("reset released before rising threshold");
    rstd_blocks_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        $past(q.rstd) && q.rstd |-> !low_supply_reset)
        else $error("reset raised while reset disabled");
    pwrd_off_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        q.pwrd |=> $stable(q.flag))
        else $error("flag moved while powered down");
    flag_sets_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (active && cmp.below_fall) |=> q.flag)
        else $error("flag not set below falling threshold");
    flag_clears_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (active && cmp.above_rise && !cmp.below_fall) |=> !q.flag)
        else $error("flag not cleared above rising threshold");
    trip_once_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        q.locked |=> $stable(q.trip))
        else $error("trip range changed after lock");
    low_resets_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (q.state == SUM_RUN && active && !q.rstd && cmp.below_fall) |=> low_supply_reset)
        else $error("no reset on low supply");
    stop_off_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (power_mode.stop_mode && !q.stop_en) |-> !monitor_on)
        else $error("monitor running in stop without enable");
    high_range_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (q.state == SUM_RUN && active && !q.rstd && q.trip && !cmp.above_rise) |=> low_supply_reset)
        else $error("high range below rising did not reset");
    // monitor on by default while powered and not stopped
    on_default_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (!q.pwrd && !power_mode.stop_mode) |-> monitor_on)
        else $error("monitor off without disable");
    // power-disable also drops a held reset on the next edge
    pwrd_no_reset_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        q.pwrd |=> !low_supply_reset)
        else $error("reset held while powered down");
    pwrd_no_events_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        q.pwrd |-> (events == 3'h0))
        else $error("event raised while powered down");
    inactive_flag_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        !active |=> $stable(q.flag))
        else $error("flag moved while monitor off");
    // reset-disable keeps run state from entering hold
    rstd_no_entry_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (q.rstd && (q.state != SUM_HOLD)) |=> !low_supply_reset)
        else $error("hold entered while reset disabled");
    rstd_flag_moves_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (active && q.rstd && cmp.below_fall && !q.flag) |=> q.flag)
        else $error("flag frozen while reset disabled");
    // stop mode with stop-enable keeps the monitor and its reset alive
    stop_runs_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (power_mode.stop_mode && q.stop_en && !q.pwrd) |-> monitor_on)
        else $error("monitor off in stop with enable");
    stop_resets_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (power_mode.stop_mode && active && !q.rstd && (q.state == SUM_RUN) && cmp.below_fall)
        |=> low_supply_reset)
        else $error("no reset out of stop");
    // wait mode does not stop the monitor
    wait_runs_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (power_mode.wait_mode && !power_mode.stop_mode && !q.pwrd) |-> monitor_on)
        else $error("monitor off in wait");
    wait_resets_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (power_mode.wait_mode && active && !q.rstd && (q.state == SUM_RUN) && cmp.below_fall)
        |=> low_supply_reset)
        else $error("no reset out of wait");
    // first configuration write takes the trip bit, later ones cannot
    trip_take_high_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (!q.locked && cfg_wr && bus_req.wdata[SUM_BIT_TRIP]) |=> q.trip)
        else $error("high range not taken on first write");
    trip_take_low_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (!q.locked && cfg_wr && !bus_req.wdata[SUM_BIT_TRIP]) |=> !q.trip)
        else $error("low range not kept on first write");
    lock_sets_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        cfg_wr |=> q.locked)
        else $error("lock not set by config write");
    lock_holds_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        q.locked |=> q.locked)
        else $error("lock dropped without reset");
    // inside the hysteresis band the flag keeps its value
    flag_holds_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (active && !cmp.below_fall && !cmp.above_rise) |=> $stable(q.flag))
        else $error("flag moved inside hysteresis band");
    hold_exit_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (low_supply_reset && active && !q.rstd && cmp.above_rise) |=> !low_supply_reset)
        else $error("reset not released above rising threshold");
    // sticky status: set wins, only a clear write removes a bit
    status_sticky_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (q.irq_status[SUM_EV_LOW] && !clr_wr) |=> q.irq_status[SUM_EV_LOW])
        else $error("status bit lost without clear");
    set_wins_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        events[SUM_EV_RESET] |=> q.irq_status[SUM_EV_RESET])
        else $error("reset event not recorded");
    irq_masked_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (q.irq_enable == 3'h0) |-> !irq)
        else $error("interrupt with all enables clear");
    // the second stage copies the first one cycle later
    lo_sync_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        1'b1 |=> (q.lo_sync == $past(q.lo_meta)))
        else $error("low comparator sync skipped a stage");
    hi_sync_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        1'b1 |=> (q.hi_sync == $past(q.hi_meta)))
        else $error("high comparator sync skipped a stage");
    // read data stand only in the cycle after a read strobe
    read_idle_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        !bus_req.rd |=> (rd_data == 8'h00))
        else $error("read data without read strobe");
    read_flag_a: assert property (@(posedge clk) disable iff (!rst_int_n)
        (bus_req.rd && (bus_req.addr == SUM_OFS_STATUS)) |=> (rd_data[SUM_BIT_FLAG] == $past(q.flag)))
        else $error("status read lost the flag");
endmodule : sum_monitor

//--- tb/sum_cmp_model.sv
// behavioural model of the low and high range supply comparators
`timescale 1ns/1ps
module sum_cmp_model #(
    parameter int LO_FALL = 20,
    parameter int LO_RISE = 25,
    parameter int HI_FALL = 40,
    parameter int HI_RISE = 45
) (
    input int level,
    output sum_pkg::sum_cmp_t cmp_lo,
    output sum_pkg::sum_cmp_t cmp_hi
);
    import sum_pkg::*;
    // rising point above falling point gives the hysteresis band
    assign cmp_lo = '{below_fall: level < LO_FALL, above_rise: level > LO_RISE};
    assign cmp_hi = '{below_fall: level < HI_FALL, above_rise: level > HI_RISE};
endmodule : sum_cmp_model

//--- tb/supply_undervoltage_monitor_test.sv
// self-checking bench for the supply undervoltage monitor
`timescale 1ns/1ps
module supply_undervoltage_monitor_test;
    import sum_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sum_bus_req_t bus_req = '0;
    sum_power_mode_t power_mode = '0;
    sum_cmp_t cmp_lo;
    sum_cmp_t cmp_hi;
    logic [7:0] rd_data;
    logic range_high, monitor_on, low_supply_reset, irq;
    int lvl = 50;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    sum_cmp_model MDL (.level(lvl), .cmp_lo(cmp_lo), .cmp_hi(cmp_hi));
    sum_monitor DUT (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
        .power_mode(power_mode), .cmp_lo(cmp_lo), .cmp_hi(cmp_hi), .range_high(range_high),
        .monitor_on(monitor_on), .low_supply_reset(low_supply_reset), .irq(irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // strobes last one cycle; outputs are looked at just after the edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1;
        chk(rd_data, exp);
    endtask : rd
    // five edges cover the two sync stages and the state update
    task automatic lv(input int v);
        @(posedge clk);
        lvl <= v;
        repeat (5) @(posedge clk);
        #1;
    endtask : lv
    task automatic pm(input logic s, input logic w);
        @(posedge clk);
        power_mode <= '{stop_mode: s, wait_mode: w};
        @(posedge clk);
        #1;
    endtask : pm
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // hang guard, far above the roughly 130 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, monitor_on}, 8'h01);
        chk({7'h00, range_high}, 8'h00);
        rd(SUM_OFS_CONFIG, SUM_CONFIG_RST);
        rd(4'hF, 8'h00);
        wr(SUM_OFS_IRQ_ENABLE, 8'h07);
        // low range drop: no reset one edge later, then reset and flag
        @(posedge clk);
        lvl <= 10;
        @(posedge clk);
        #1;
        chk({7'h00, low_supply_reset}, 8'h00);
        repeat (4) @(posedge clk);
        #1;
        chk({7'h00, low_supply_reset}, 8'h01);
        rd(SUM_OFS_STATUS, 8'h80);
        lv(22);
        chk({7'h00, low_supply_reset}, 8'h01);
        rd(SUM_OFS_STATUS, 8'h80);
        lv(30);
        chk({7'h00, low_supply_reset}, 8'h00);
        rd(SUM_OFS_STATUS, 8'h00);
        chk({7'h00, irq}, 8'h01);
        rd(SUM_OFS_IRQ_STATUS, 8'h07);
        wr(SUM_OFS_IRQ_CLEAR, 8'h07);
        wr(SUM_OFS_IRQ_ENABLE, 8'h00);
        chk({7'h00, irq}, 8'h00);
        // high range chosen while below its rising point
        wr(SUM_OFS_CONFIG, 8'h08);
        repeat (4) @(posedge clk);
        #1;
        chk({7'h00, range_high}, 8'h01);
        chk({7'h00, low_supply_reset}, 8'h01);
        wr(SUM_OFS_CONFIG, 8'h00);
        rd(SUM_OFS_CONFIG, 8'h18);
        lv(50);
        chk({7'h00, low_supply_reset}, 8'h00);
        // resets suppressed, flag still polled
        wr(SUM_OFS_CONFIG, 8'h04);
        lv(35);
        chk({7'h00, low_supply_reset}, 8'h00);
        rd(SUM_OFS_STATUS, 8'h80);
        chk({7'h00, irq}, 8'h00);
        lv(50);
        rd(SUM_OFS_STATUS, 8'h00);
        // monitor switched off
        wr(SUM_OFS_CONFIG, 8'h02);
        chk({7'h00, monitor_on}, 8'h00);
        lv(35);
        chk({7'h00, low_supply_reset}, 8'h00);
        rd(SUM_OFS_STATUS, 8'h00);
        lv(50);
        // stop needs the stop enable, wait always runs
        wr(SUM_OFS_CONFIG, 8'h00);
        pm(1'b1, 1'b0);
        chk({7'h00, monitor_on}, 8'h00);
        wr(SUM_OFS_CONFIG, 8'h01);
        chk({7'h00, monitor_on}, 8'h01);
        lv(35);
        chk({7'h00, low_supply_reset}, 8'h01);
        lv(50);
        pm(1'b0, 1'b1);
        lv(35);
        chk({7'h00, low_supply_reset}, 8'h01);
        lv(50);
        give_verdict();
    end
endmodule : supply_undervoltage_monitor_test
